//--- rtl/seq_rd_pkg.sv
/*
  constants shared by the serial read slave and the bus master end:
  slave address patterns, address width, byte width, bit timing.
  assumes both ends run on one clock, mclk at 200 MHz.
*/
package seq_rd_pkg;
  // **********************************************************
  // address patterns
  // **********************************************************
  localparam logic [6:0]  mem_slave_addr   = 7'h57; // memory array, 1010111
  localparam logic [6:0]  ctl_slave_addr   = 7'h6f; // clock_control_register_space, 1101111
  localparam int          addr_w           = 16;    // word address counter width
  localparam logic [15:0] addr_reset_val   = 16'h0000;
  localparam int          byte_w           = 8;
  localparam logic [3:0]  ninth_bit        = 4'h8;  // bit index of acknowledge slot
  localparam logic        dir_read         = 1'b1;
  localparam logic        dir_write        = 1'b0;
  // **********************************************************
  // bit timing of the master end
  // **********************************************************
  localparam int          clk_mhz          = 200;
  localparam int          quarter_ns       = 625;   // quarter of a 400 kHz bit period
  localparam int          quarter_cyc      = (quarter_ns * clk_mhz) / 1000;
  localparam logic [9:0]  quarter_cnt      = 10'(quarter_cyc - 1);
endpackage : seq_rd_pkg

//--- rtl/two_wire_if.sv
/*
  two-wire bus between the master end and the slave end.
  assumes open drain wires with pull-ups; each end drives only low.
*/
`timescale 1ns/1ps
interface two_wire_if;
  logic scl_o;     // master clock drive value
  logic scl_oe;    // master pulls clock low while high
  logic sda_m_oe;  // master pulls data low while high
  logic sda_s_oe;  // slave pulls data low while high
  logic scl;       // resolved clock level
  logic sda;       // resolved data level
  // wired-and of the open drain drivers
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_o, output scl_oe, output sda_m_oe, input scl, input sda);
  modport slave  (output sda_s_oe, input scl, input sda);
endinterface : two_wire_if

//--- rtl/seq_rd_slave.sv
/*
  slave end of the serial bus: slave byte compare, word address load,
  current, random and sequential reads from a byte memory.
  assumes scl and sda are synchronous to mclk and held for many cycles.
*/
// Notes on behaviour
// - counter holds last read address plus one
// - counter clears to zero at reset
// - read slave byte acked, eight bits follow
// - master ends read with nack, stop
// - master dummy-writes address before random read
// - repeated start then read from loaded address
// - stop after address loads counter, standby
// - next current read starts at loaded address
// - each master ack gets next byte
// - counter crosses page and column boundaries
// - counter wraps at end, reading continues
// - ack only matching seven bit patterns
// - two address bytes follow write slave byte
// - same slave byte in both random read parts
// - no ack ends transmit, stop returns standby
`timescale 1ns/1ps
module seq_rd_slave
  import seq_rd_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           clk_en,     // freezes all state when low
  two_wire_if.slave                           bus,
  output logic      [seq_rd_pkg::addr_w-1:0]  cur_addr,   // word address counter
  output logic                                busy,       // inside a selected transfer
  output logic                                space_ctl,  // last access went to control space
  input  wire logic                           wr_en,      // user loads memory contents
  input  wire logic [seq_rd_pkg::addr_w-1:0]  wr_addr,
  input  wire logic [seq_rd_pkg::byte_w-1:0]  wr_data
);
  import seq_rd_pkg::*;

  // **********************************************************
  // state and storage
  // **********************************************************
  typedef enum logic [2:0]
  {
    st_idle  = 3'b000,  // standby, waits for start
    st_slave = 3'b001,  // shifting in slave byte
    st_ahi   = 3'b010,  // high address byte
    st_alo   = 3'b011,  // low address byte
    st_wdat  = 3'b100,  // write data, acked and dropped
    st_tx    = 3'b101,  // shifting data out
    st_mack  = 3'b110   // sampling master acknowledge
  } slv_e;

  typedef struct packed
  {
    slv_e                st;
    logic [3:0]          bitn;    // bit count within byte
    logic [7:0]          sh;      // shift register
    logic                ack;     // pulling sda for our acknowledge
    logic                drv;     // pulling sda for a zero data bit
    logic                scl_p;   // last clock level
    logic                sda_p;   // last data level
    logic [15:0]         addr;    // word address counter
    logic [7:0]          ahi;     // held high address byte
    logic                ctl;     // selected space
    logic                busy;
  } slv_s;

  slv_s slv_q;     // registered state
  slv_s slv_d;     // next state
  logic [7:0] mem [0:(1<<addr_w)-1];  // shared backing store for both spaces
  logic [7:0] rd_byte;                 // byte at counter

  // user side write port into the store
  always_ff @(posedge mclk)
  begin
    if (clk_en && wr_en)
      mem[wr_addr] <= wr_data;
  end

  assign rd_byte = mem[slv_q.addr];

  // **********************************************************
  // protocol engine
  // **********************************************************
  logic rise;   // clock rising
  logic fall;   // clock falling
  logic start;  // data falls while clock high
  logic stop;   // data rises while clock high
  assign rise  = bus.scl & ~slv_q.scl_p;
  assign fall  = ~bus.scl & slv_q.scl_p;
  assign start = bus.scl & slv_q.scl_p & slv_q.sda_p & ~bus.sda;
  assign stop  = bus.scl & slv_q.scl_p & ~slv_q.sda_p & bus.sda;

  // next state of the whole slave
  always_comb
  begin
    slv_d = slv_q;
    slv_d.scl_p = bus.scl;
    slv_d.sda_p = bus.sda;
    if (stop)
    begin
      // ends any transfer; an address already loaded stays loaded
      slv_d.st   = st_idle;
      slv_d.ack  = 1'b0;
      slv_d.drv  = 1'b0;
      slv_d.busy = 1'b0;
    end
    else if (start)
    begin
      // repeated start is legal anywhere, even mid byte
      slv_d.st   = st_slave;
      slv_d.bitn = 4'h0;
      slv_d.ack  = 1'b0;
      slv_d.drv  = 1'b0;
    end
    else if (slv_q.st != st_idle)
    begin
      if (fall && slv_q.ack)
        slv_d.ack = 1'b0;  // release after acknowledge slot
      if (slv_q.st == st_tx)
      begin
        if (fall)
        begin
          // change sda only while scl low, msb first
          if (slv_q.bitn == ninth_bit)
          begin
            slv_d.drv = 1'b0;   // release for master ack
            slv_d.st  = st_mack;
          end
          else
          begin
            slv_d.drv = ~slv_q.sh[7];
            slv_d.sh  = {slv_q.sh[6:0], 1'b0};
          end
        end
        if (rise)
          slv_d.bitn = slv_q.bitn + 4'h1;
      end
      else if (slv_q.st == st_mack)
      begin
        if (rise)
        begin
          if (!bus.sda)
          begin
            // acked: fetch next byte, counter already advanced
            slv_d.st   = st_tx;
            slv_d.sh   = rd_byte;
            slv_d.bitn = 4'h0;
            slv_d.addr = slv_q.addr + 16'h0001;  // wraps past ffff
          end
          else
            slv_d.st = st_idle;  // nack ends transmit until stop
        end
      end
      else if (rise && slv_q.bitn < ninth_bit && !slv_q.ack)
      begin
        // receive shift on rising edge; the ack slot rise is not a data bit
        slv_d.sh   = {slv_q.sh[6:0], bus.sda};
        slv_d.bitn = slv_q.bitn + 4'h1;
      end
      else if (fall && slv_q.bitn == ninth_bit && !slv_q.ack)
      begin
        // eighth bit complete: decide and acknowledge
        slv_d.bitn = 4'h0;
        unique case (slv_q.st)
          st_slave:
          begin
            if (slv_q.sh[7:1] == mem_slave_addr || slv_q.sh[7:1] == ctl_slave_addr)
            begin
              slv_d.ack  = 1'b1;
              slv_d.busy = 1'b1;
              slv_d.ctl  = (slv_q.sh[7:1] == ctl_slave_addr);
              if (slv_q.sh[0] == dir_read)
              begin
                // first byte from current counter
                slv_d.st   = st_tx;
                slv_d.sh   = rd_byte;
                slv_d.bitn = 4'hf;  // ack slot counts as one rise
                slv_d.addr = slv_q.addr + 16'h0001;
              end
              else
                slv_d.st = st_ahi;
            end
            else
              slv_d.st = st_idle;   // no match: stays off the bus
          end
          st_ahi:
          begin
            slv_d.ack = 1'b1;
            slv_d.ahi = slv_q.sh;
            slv_d.st  = st_alo;
          end
          st_alo:
          begin
            slv_d.ack  = 1'b1;
            slv_d.addr = {slv_q.ahi, slv_q.sh};  // loaded now
            slv_d.st   = st_wdat;
          end
          st_wdat:
            slv_d.ack = 1'b1;  // write data belongs to the write path
          default:
            slv_d.st = st_idle;
        endcase
      end
      else if (rise && slv_q.st == st_tx)
        slv_d.bitn = slv_q.bitn;
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slv_q       <= '0;
      slv_q.st    <= st_idle;
      slv_q.scl_p <= 1'b1;
      slv_q.sda_p <= 1'b1;
      slv_q.addr  <= addr_reset_val;
    end
    else if (clk_en)
      slv_q <= slv_d;
  end

  // outputs from flip-flops; the sda drive is the OR of the ack and drv flip-flops
  assign bus.sda_s_oe = slv_q.ack | slv_q.drv;
  assign cur_addr     = slv_q.addr;
  assign busy         = slv_q.busy;
  assign space_ctl    = slv_q.ctl;
endmodule : seq_rd_slave

//--- rtl/seq_rd_master.sv
/*
  master end: performs current, random, sequential reads and set-address.
  assumes one slave on the bus and no clock stretching.
*/
`timescale 1ns/1ps
module seq_rd_master
  import seq_rd_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           clk_en,
  two_wire_if.master                          bus,
  input  wire logic                           cmd_valid,  // one-cycle request
  input  wire logic                           cmd_ctl,    // control space when high
  input  wire logic                           cmd_setaddr,// send address first
  input  wire logic                           cmd_read,   // read after address
  input  wire logic [seq_rd_pkg::addr_w-1:0]  cmd_addr,
  input  wire logic [7:0]                     cmd_len,    // bytes to read minus one
  output logic                                cmd_ready,
  output logic                                rd_valid,   // one-cycle pulse per byte
  output logic      [7:0]                     rd_data,
  output logic                                nak_err     // slave did not ack
);
  import seq_rd_pkg::*;

  typedef enum logic [2:0]
  {
    m_idle  = 3'b000,
    m_start = 3'b001,
    m_byte  = 3'b010,
    m_stop  = 3'b011
  } mst_e;

  typedef struct packed
  {
    mst_e       st;
    logic [9:0] tq;     // quarter timer
    logic [1:0] ph;     // quarter phase
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] step;   // 0 slave wr,1 hi,2 lo,3 read phase
    logic       rd;     // current byte is received
    logic [7:0] left;
    logic       sda_oe;
    logic       scl_lo;
    logic       ready;
    logic       rv;
    logic [7:0] rdat;
    logic       err;
    logic       ctl;
    logic       doread;
    logic [15:0] addr;
  } mst_s;

  mst_s m_q;
  mst_s m_d;
  logic tick;
  assign tick = (m_q.tq == quarter_cnt);

  // sequencer: each bit is four quarter periods, clock low in 0 and 1
  always_comb
  begin
    m_d    = m_q;
    m_d.rv = 1'b0;
    m_d.tq = tick ? 10'h000 : m_q.tq + 10'h001;
    unique case (m_q.st)
      m_idle:
      begin
        m_d.tq = 10'h000;
        m_d.ready = 1'b1;
        if (cmd_valid)
        begin
          m_d.ready  = 1'b0;
          m_d.ctl    = cmd_ctl;
          m_d.addr   = cmd_addr;
          m_d.left   = cmd_len;
          m_d.doread = cmd_read;
          m_d.step   = cmd_setaddr ? 2'h0 : 2'h3;
          m_d.st     = m_start;
          m_d.ph     = 2'h0;
        end
      end
      m_start:
        if (tick)
        begin
          m_d.ph = m_q.ph + 2'h1;
          if (m_q.ph == 2'h0)
          begin
            m_d.sda_oe = 1'b0;
            m_d.scl_lo = 1'b0;
          end
          if (m_q.ph == 2'h1) m_d.sda_oe = 1'b1;
          if (m_q.ph == 2'h2)
          begin
            m_d.scl_lo = 1'b1;
            m_d.st     = m_byte;
            m_d.bitn   = 4'h0;
            m_d.ph     = 2'h0;
            m_d.rd     = 1'b0;
            m_d.sh     = {m_q.ctl ? ctl_slave_addr : mem_slave_addr,
                          (m_q.step == 2'h3) ? dir_read : dir_write};
          end
        end
      m_byte:
        if (tick)
        begin
          m_d.ph = m_q.ph + 2'h1;
          if (m_q.ph == 2'h0)
          begin
            // set data while clock low
            if (m_q.bitn == ninth_bit)
              m_d.sda_oe = m_q.rd && (m_q.left != 8'h00);  // ack to continue
            else
              m_d.sda_oe = m_q.rd ? 1'b0 : ~m_q.sh[7];
          end
          if (m_q.ph == 2'h1) m_d.scl_lo = 1'b0;
          if (m_q.ph == 2'h2)
          begin
            if (m_q.bitn == ninth_bit)
            begin
              if (!m_q.rd && bus.sda) m_d.err = 1'b1;
            end
            else
              m_d.sh = {m_q.sh[6:0], m_q.rd ? bus.sda : 1'b0};
          end
          if (m_q.ph == 2'h3)
          begin
            m_d.scl_lo = 1'b1;
            m_d.bitn   = m_q.bitn + 4'h1;
            // let go of data with the fall before the slave ack slot,
            // so both ends never pull the line in the same cycle
            if (m_q.bitn == 4'h7 && !m_q.rd)
              m_d.sda_oe = 1'b0;
            if (m_q.bitn == ninth_bit)
            begin
              m_d.bitn = 4'h0;
              m_d.sda_oe = 1'b0;
              if (m_q.rd)
              begin
                m_d.rv   = 1'b1;
                m_d.rdat = m_q.sh;
                m_d.left = m_q.left - 8'h01;
                if (m_q.left == 8'h00) m_d.st = m_stop;
              end
              else if (m_d.err) m_d.st = m_stop;
              else if (m_q.step == 2'h3) m_d.rd = 1'b1;
              else if (m_q.step == 2'h0)
              begin
                m_d.step = 2'h1;
                m_d.sh   = m_q.addr[15:8];
              end
              else if (m_q.step == 2'h1)
              begin
                m_d.step = 2'h2;
                m_d.sh   = m_q.addr[7:0];
              end
              else if (m_q.doread)
              begin
                m_d.step = 2'h3;
                m_d.st   = m_start;
              end
              else m_d.st = m_stop;  // set current address
            end
          end
        end
      m_stop:
        if (tick)
        begin
          m_d.ph = m_q.ph + 2'h1;
          if (m_q.ph == 2'h0) m_d.sda_oe = 1'b1;
          if (m_q.ph == 2'h1) m_d.scl_lo = 1'b0;
          if (m_q.ph == 2'h2) m_d.sda_oe = 1'b0;
          if (m_q.ph == 2'h3) m_d.st = m_idle;
        end
      default:
        m_d.st = m_idle;
    endcase
    if (m_q.st == m_idle && cmd_valid) m_d.err = 1'b0;
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      m_q    <= '0;
      m_q.st <= m_idle;
    end
    else if (clk_en)
      m_q <= m_d;
  end

  assign bus.scl_o    = ~m_q.scl_lo;
  assign bus.scl_oe   = m_q.scl_lo;
  assign bus.sda_m_oe = m_q.sda_oe;
  assign cmd_ready    = m_q.ready;
  assign rd_valid     = m_q.rv;
  assign rd_data      = m_q.rdat;
  assign nak_err      = m_q.err;
endmodule : seq_rd_master

//--- test/seq_rd_monitor.sv
/*
  wire checker for the two-wire bus joining the master and slave ends.
  assumes the bench places it beside the interface; one clock, mclk.
*/
`timescale 1ns/1ps
module seq_rd_monitor
(
  input  wire logic  mclk,      // system clock
  input  wire logic  rst,       // sync reset, high
  input  wire logic  scl_o,     // master clock drive value
  input  wire logic  scl_oe,    // master clock enable
  input  wire logic  sda_m_oe,  // master pulls data low
  input  wire logic  sda_s_oe,  // slave pulls data low
  input  wire logic  scl,       // resolved clock
  input  wire logic  sda        // resolved data
);
  // **********************************************************
  // frame tracking
  // **********************************************************
  logic  sda_q;    // data one cycle back
  logic  idle_q;   // between stop and start
  logic  start_w;  // data falls while clock high
  logic  stop_w;   // data rises while clock high
  assign start_w = scl && sda_q && !sda;
  assign stop_w  = scl && !sda_q && sda;
  // reset counts as an idle bus
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sda_q  <= 1'b1;
      idle_q <= 1'b1;
    end
    else
    begin
      sda_q <= sda;
      if (start_w)
        idle_q <= 1'b0;
      else if (stop_w)
        idle_q <= 1'b1;
    end
  end
  // **********************************************************
  // properties
  // **********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_start;
    start_w;
  endsequence
  sequence s_low_hold;
    !scl [*8];
  endsequence
  sequence s_high_hold;
    scl [*8];
  endsequence
  property p_idle_quiet;
    idle_q |-> !sda_s_oe && !(scl_oe && !scl_o);
  endproperty
  property p_slave_rise;
    $rose(sda_s_oe) |-> !scl;
  endproperty
  property p_slave_fall;
    $fell(sda_s_oe) |-> !scl;
  endproperty
  property p_no_clash;
    !(sda_m_oe && sda_s_oe);
  endproperty
  property p_start_by_master;
    s_start |-> sda_m_oe && !sda_s_oe;
  endproperty
  property p_start_then_clock;
    s_start |-> ##[1:300] !scl;
  endproperty
  property p_low_min;
    $fell(scl) |=> s_low_hold;
  endproperty
  property p_high_min;
    $rose(scl) |=> s_high_hold;
  endproperty
  property p_clk_runs;
    $fell(scl) |-> ##[1:600] scl;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("bus driven while idle");
  a_slave_rise: assert property (p_slave_rise)
    else $error("slave pulled data with clock high");
  a_slave_fall: assert property (p_slave_fall)
    else $error("slave released data with clock high");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data");
  a_start_by_master: assert property (p_start_by_master)
    else $error("start not made by master");
  a_start_then_clock: assert property (p_start_then_clock)
    else $error("no clock after start");
  a_low_min: assert property (p_low_min)
    else $error("clock low too short");
  a_high_min: assert property (p_high_min)
    else $error("clock high too short");
  a_clk_runs: assert property (p_clk_runs)
    else $error("clock stuck low");
endmodule : seq_rd_monitor

//--- test/tb_serial_read_address_counter.sv
/*
  self-checking bench: master end drives reads against the slave end.
  assumes the package constants; store contents loaded by the bench.
*/
`timescale 1ns/1ps
module tb_serial_read_address_counter;
  import seq_rd_pkg::*;
  logic        mclk, rst, wr_en, cmd_valid, cmd_ctl;   // clock and controls
  logic        cmd_setaddr, cmd_read, cmd_ready;       // command handshake
  logic        rd_valid, nak_err, busy, space_ctl;     // status outputs
  logic [15:0] wr_addr, cmd_addr, cur_addr, base, exp_ctr;
  logic [7:0]  wr_data, cmd_len, rd_data, key;
  int          num_errors, checks_done;
  two_wire_if bus_i ();
  seq_rd_slave seq_rd_slave_i (.mclk(mclk), .rst(rst), .clk_en(1'b1), .bus(bus_i.slave),
    .cur_addr(cur_addr), .busy(busy), .space_ctl(space_ctl), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data));
  seq_rd_master seq_rd_master_i (.mclk(mclk), .rst(rst), .clk_en(1'b1), .bus(bus_i.master),
    .cmd_valid(cmd_valid), .cmd_ctl(cmd_ctl), .cmd_setaddr(cmd_setaddr),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .nak_err(nak_err));
  seq_rd_monitor seq_rd_monitor_i (.mclk(mclk), .rst(rst), .scl_o(bus_i.scl_o),
    .scl_oe(bus_i.scl_oe), .sda_m_oe(bus_i.sda_m_oe), .sda_s_oe(bus_i.sda_s_oe),
    .scl(bus_i.scl), .sda(bus_i.sda));
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // **********************************************************
  // expectation and compare helpers
  // **********************************************************
  // store pattern, keyed so a stuck address shows
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ key;
  endfunction : exp_byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t data %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t counter %h want %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // bounded wait; a hang ends the run
  task automatic wait_ready(input int lim);
    int t;
    t = 0;
    while (cmd_ready !== 1'b1 && t < lim)
    begin
      @(negedge mclk);
      t++;
    end
    if (t >= lim)
    begin
      num_errors++;
      $display("MISMATCH %0t ready timeout", $time);
      test_done;
    end
  endtask : wait_ready
  // one command, every byte compared against the model counter
  task automatic run_cmd(input logic ctl, input logic sa, input logic rd,
                         input logic [15:0] a, input logic [7:0] len);
    int n;
    int t;
    wait_ready(100);
    @(posedge mclk);
    cmd_valid   <= 1'b1;
    cmd_ctl     <= ctl;
    cmd_setaddr <= sa;
    cmd_read    <= rd;
    cmd_addr    <= a;
    cmd_len     <= len;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // step off the taking edge so ready is seen after it drops
    @(negedge mclk);
    if (sa)
      exp_ctr = a;
    n = 0;
    t = 0;
    while (rd && n <= int'(len) && t < 80000)
    begin
      @(negedge mclk);
      t++;
      if (rd_valid === 1'b1)
      begin
        chk8(rd_data, exp_byte(exp_ctr));
        chk1(busy, 1'b1);
        exp_ctr++;
        n++;
      end
    end
    if (rd && n <= int'(len))
    begin
      num_errors++;
      $display("MISMATCH %0t byte timeout", $time);
      test_done;
    end
    wait_ready(60000);
    repeat (4) @(negedge mclk);
    chk16(cur_addr, exp_ctr);
    chk1(space_ctl, ctl);
    chk1(nak_err, 1'b0);
    chk1(busy, 1'b0);
  endtask : run_cmd
  // **********************************************************
  // main sequence
  // **********************************************************
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    wr_en = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 8'h00;
    cmd_valid = 1'b0;
    cmd_ctl = 1'b0;
    cmd_setaddr = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 16'h0000;
    cmd_len = 8'h00;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'h8498fecd));
    key = 8'($urandom);
    base = 16'($urandom) | 16'h000f; // start on a page end
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // load the locations that get read, plus 0001 which is never read
    for (int i = 0; i < 7; i++)
    begin
      @(posedge mclk);
      wr_en   <= 1'b1;
      wr_addr <= (i < 4) ? base + 16'(i) : 16'(i - 5);
      wr_data <= exp_byte((i < 4) ? base + 16'(i) : 16'(i - 5));
    end
    @(posedge mclk);
    wr_en <= 1'b0;
    @(negedge mclk);
    exp_ctr = 16'h0000;
    chk16(cur_addr, 16'h0000);
    run_cmd(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00);
    run_cmd(1'b0, 1'b1, 1'b0, 16'hffff, 8'h00);
    run_cmd(1'b0, 1'b0, 1'b1, 16'h0000, 8'h01);
    run_cmd(1'b1, 1'b1, 1'b1, base, 8'h02);
    run_cmd(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00);
    test_done;
  end
endmodule : tb_serial_read_address_counter
